// ---- include/serial_port_consts.svh ----
/*
  Offsets, field positions, reset values and frame counts of the
  synthesizer serial port.
  Assumes it is included by bare name after the package.
*/
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// Register offsets
`define OFS_DEVICE_IDENTITY 6'h00
`define OFS_SDO_FORCE 6'h02
`define OFS_PIN_MUX 6'h1a

// Field positions
`define POS_FORCE_VAL 0
`define POS_FORCE_EN 1
`define POS_AUTO_SHARE 12
`define POS_LOCK_ONLY 13

// Reset values of the pin control bits
`define RST_FORCE_VAL 1'h1
`define RST_FORCE_EN 1'h1
`define RST_AUTO_SHARE 1'h1
`define RST_LOCK_ONLY 1'h0

// Rising edges seen before the edge that does the work
`define CNT_FLAG 6'h00
`define CNT_ADDR_LAST 6'h06
`define CNT_DATA_LAST 6'h1e
`define CNT_COMPLETE 6'h1f
`define CNT_DONE 6'h20

`endif

// ---- include/serial_port_pkg.sv ----
/*
  Types used by the serial port slave, not by its register store.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package serial_port_pkg;

  // A completed write frame
  typedef struct packed {
    logic [5:0] addr;
    logic [23:0] data;
  } commit_t;

  // Pin sharing controls
  typedef struct packed {
    logic lock_only;
    logic auto_share;
    logic force_en;
    logic force_val;
  } pin_cfg_t;

endpackage

`default_nettype wire

// ---- logic/word_store.sv ----
/*
  Small register store: one write port, one read port, registered read.
  Assumes both ports run on the same clock.
*/
`default_nettype none

module word_store #(
  parameter int WIDTH = 24,
  parameter int ADDR_W = 6
) (
  // Clock
  input wire logic clock,
  // Write side
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

  // Write and registered read
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// ---- logic/synth_serial_port_slave.sv ----
/*
  Four-wire serial slave port with shared lock-detect / read-data pin.
  Frame logic runs on the host serial clock and is cleared whenever the
  port enable is low; pin sharing runs on the system clock.
  Assumes serial data in is timed to the serial clock by the host.
*/
// What this block does
// - First rising edge after enable samples data in: low write, high read.
// - Address bits are captured on rising edges two to seven.
// - Write data bits are captured on rising edges eight to thirty-one.
// - Thirty-second rising edge completes a write frame.
// - Read data leaves MSB first, updated on rising edges eight to 31.
// - Thirty-second falling edge completes a read frame.
// - Both mux bits clear: the pin only carries read data.
// - Auto sharing switches the pin to read data once a read is flagged; it stays released if force enable is set and force value clear.
// - Lock-only set: pin carries lock detect if force enable and value are set, reads never appear.
// - Address zero reads a fixed 24-bit identity, writes ignored.
// - Auto sharing without a read: pin shows lock detect if force enable and value are set, else it is released.
// - Pure read mode drives the pin only during a read.
`default_nettype none
`include "serial_port_consts.svh"

module synth_serial_port_slave #(
  parameter logic [23:0] DEVICE_ID = 24'h00a5a5 // Arbitrary value
) (
  // System clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Serial link from the host
  input wire logic serial_clock,
  input wire logic port_select_enable,
  input wire logic serial_data_in,
  // Lock status from the synthesizer, system clock domain
  input wire logic lock_detect,
  // Shared output pin
  output logic lock_or_readout_pin_o,
  output logic lock_or_readout_pin_oe
);

  // ---------------- Serial clock domain ----------------
  logic [5:0] cnt_reg, cnt_next;
  logic read_reg, read_next;
  logic [5:0] addr_reg, addr_next;
  logic [23:0] data_reg, data_next;
  logic out_bit_reg, out_bit_next;
  logic done_reg, done_next;
  serial_port_pkg::commit_t commit_reg, commit_next;
  logic read_end_reg;
  logic [23:0] store_rd;
  logic [23:0] read_word;
  logic [5:0] addr_shifted;
  logic store_wr;

  assign addr_shifted = {addr_reg[4:0], serial_data_in};
  // Address zero answers with the fixed identity
  assign read_word = (addr_reg == `OFS_DEVICE_IDENTITY) ?
                     DEVICE_ID : store_rd;
  // Address zero is never written
  assign store_wr = (cnt_reg == `CNT_COMPLETE) && !read_reg &&
                    (addr_reg != `OFS_DEVICE_IDENTITY);

  word_store #(
    .WIDTH(24),
    .ADDR_W(6)
  ) u_store (
    .clock(serial_clock),
    .wr_en(store_wr),
    .wr_addr(addr_reg),
    .wr_data(data_reg),
    .rd_addr(addr_shifted),
    .rd_data(store_rd)
  );

  // Frame sequencing on rising serial clock edges
  always_comb begin
    cnt_next = cnt_reg;
    read_next = read_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    out_bit_next = out_bit_reg;
    done_next = done_reg;
    commit_next = commit_reg;
    if (cnt_reg != `CNT_DONE) begin
      cnt_next = cnt_reg + 6'h01;
    end
    if (cnt_reg == `CNT_FLAG) begin
      read_next = serial_data_in;
    end else if (cnt_reg <= `CNT_ADDR_LAST) begin
      addr_next = addr_shifted;
    end else if (cnt_reg <= `CNT_DATA_LAST) begin
      if (read_reg) begin
        // First data edge loads the word, later ones shift it
        if (cnt_reg == `CNT_ADDR_LAST + 6'h01) begin
          out_bit_next = read_word[23];
          data_next = {read_word[22:0], 1'h0};
        end else begin
          out_bit_next = data_reg[23];
          data_next = {data_reg[22:0], 1'h0};
        end
      end else begin
        data_next = {data_reg[22:0], serial_data_in};
      end
    end else if (cnt_reg == `CNT_COMPLETE && !read_reg) begin
      done_next = 1'h1;
      commit_next = '{addr: addr_reg, data: data_reg};
    end
  end

  // Frame state clears whenever enable drops, dropping short frames
  always_ff @(posedge serial_clock or negedge port_select_enable) begin
    if (!port_select_enable) begin
      cnt_reg <= 6'h00;
      read_reg <= 1'h0;
      addr_reg <= 6'h00;
      data_reg <= 24'h000000;
      out_bit_reg <= 1'h0;
      done_reg <= 1'h0;
    end else begin
      cnt_reg <= cnt_next;
      read_reg <= read_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      out_bit_reg <= out_bit_next;
      done_reg <= done_next;
    end
  end

  // Committed word stays put until the next full write frame
  always_ff @(posedge serial_clock) begin
    commit_reg <= commit_next;
  end

  // Read frame ends on the thirty-second falling edge
  always_ff @(negedge serial_clock or negedge port_select_enable) begin
    if (!port_select_enable) begin
      read_end_reg <= 1'h0;
    end else if (read_reg && cnt_reg == `CNT_DONE) begin
      read_end_reg <= 1'h1;
    end
  end

  AST_FLAG_SAMPLE: assert property (@(posedge serial_clock)
    disable iff (!port_select_enable)
    cnt_reg == `CNT_FLAG |=> read_reg == $past(serial_data_in))
    else $error("read flag not taken from first edge");

  AST_ADDR_DONE: assert property (@(posedge serial_clock)
    disable iff (!port_select_enable)
    cnt_reg == `CNT_FLAG ##1 1'b1 [*5] ##1 cnt_reg == `CNT_ADDR_LAST
    |=> addr_reg[0] == $past(serial_data_in))
    else $error("address not complete after edge seven");

  // Rising edge 32 is the last one, so this looks from the system clock
  AST_WRITE_DONE: assert property (@(posedge clock)
    disable iff (!port_select_enable)
    cnt_reg == `CNT_DONE && !read_reg |-> done_reg &&
    commit_reg.addr == addr_reg && commit_reg.data == data_reg)
    else $error("write not completed on edge thirty-two");

  AST_NO_EARLY_COMMIT: assert property (@(posedge serial_clock)
    disable iff (!port_select_enable)
    cnt_reg < `CNT_COMPLETE |=> !done_reg)
    else $error("write committed before full frame");

  AST_READ_MSB: assert property (@(posedge serial_clock)
    disable iff (!port_select_enable)
    read_reg && cnt_reg == `CNT_ADDR_LAST + 6'h01
    |=> out_bit_reg == $past(read_word[23]) ##1
    out_bit_reg == $past(read_word[22], 2))
    else $error("read data not shifted MSB first");

  // Falling edge 32 is the last one, so this looks from the system clock
  AST_READ_END: assert property (@(posedge clock)
    disable iff (!port_select_enable)
    read_reg && cnt_reg == `CNT_DONE && !serial_clock |-> read_end_reg)
    else $error("read frame not ended on edge thirty-two");

  // ---------------- System clock domain ----------------
  logic [1:0] done_sync_reg, read_sync_reg, end_sync_reg, bit_sync_reg;
  logic done_seen_reg;
  serial_port_pkg::pin_cfg_t cfg_reg, cfg_next;
  logic pin_out_next, pin_oe_next;
  logic read_active;
  logic drive_en;

  // Two-flop synchronisers for the frame levels and the data bit
  always_ff @(posedge clock) begin
    done_sync_reg <= {done_sync_reg[0], done_reg};
    read_sync_reg <= {read_sync_reg[0], read_reg};
    end_sync_reg <= {end_sync_reg[0], read_end_reg};
    bit_sync_reg <= {bit_sync_reg[0], out_bit_reg};
  end

  assign read_active = read_sync_reg[1] && !end_sync_reg[1];
  // Driver enable either forced or following the read
  assign drive_en = cfg_reg.force_en ? cfg_reg.force_val : read_active;

  // Pin controls follow committed writes to their registers
  always_comb begin
    cfg_next = cfg_reg;
    if (done_sync_reg[1] && !done_seen_reg) begin
      if (commit_reg.addr == `OFS_SDO_FORCE) begin
        cfg_next.force_val = commit_reg.data[`POS_FORCE_VAL];
        cfg_next.force_en = commit_reg.data[`POS_FORCE_EN];
      end else if (commit_reg.addr == `OFS_PIN_MUX) begin
        cfg_next.auto_share = commit_reg.data[`POS_AUTO_SHARE];
        cfg_next.lock_only = commit_reg.data[`POS_LOCK_ONLY];
      end
    end
  end

  // Pin sharing
  always_comb begin
    if (cfg_reg.lock_only) begin
      pin_out_next = lock_detect;
      pin_oe_next = cfg_reg.force_en && cfg_reg.force_val;
    end else if (cfg_reg.auto_share) begin
      pin_out_next = read_active ? bit_sync_reg[1] :
                     lock_detect;
      pin_oe_next = drive_en;
    end else begin
      pin_out_next = bit_sync_reg[1];
      pin_oe_next = read_active;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done_seen_reg <= 1'h0;
      cfg_reg <= '{lock_only: `RST_LOCK_ONLY, auto_share: `RST_AUTO_SHARE,
                   force_en: `RST_FORCE_EN, force_val: `RST_FORCE_VAL};
      lock_or_readout_pin_o <= 1'h0;
      lock_or_readout_pin_oe <= 1'h0;
    end else begin
      done_seen_reg <= done_sync_reg[1];
      cfg_reg <= cfg_next;
      lock_or_readout_pin_o <= pin_out_next;
      lock_or_readout_pin_oe <= pin_oe_next;
    end
  end

  AST_LOCK_ONLY: assert property (@(posedge clock)
    disable iff (sys_rst)
    cfg_reg.lock_only |=> lock_or_readout_pin_o == $past(lock_detect))
    else $error("read data leaked in lock-only mode");

  AST_AUTO_IDLE: assert property (@(posedge clock)
    disable iff (sys_rst)
    cfg_reg.auto_share && !cfg_reg.lock_only && !read_active
    |=> lock_or_readout_pin_o == $past(lock_detect))
    else $error("lock detect missing outside read");

  AST_AUTO_READ: assert property (@(posedge clock)
    disable iff (sys_rst)
    cfg_reg.auto_share && !cfg_reg.lock_only && read_active
    |=> lock_or_readout_pin_o == $past(bit_sync_reg[1]))
    else $error("read data missing in auto mode");

  AST_PURE_OE: assert property (@(posedge clock)
    disable iff (sys_rst)
    !cfg_reg.auto_share && !cfg_reg.lock_only
    |=> lock_or_readout_pin_oe == $past(read_active) &&
    lock_or_readout_pin_o == $past(bit_sync_reg[1]))
    else $error("pure read mode drives out of a read");

endmodule

`default_nettype wire

// ---- test/serial_host.sv ----
/*
  Host controller model: drives serial frames, samples read data.
  Assumes the bench resolves the shared pin and feeds its level here.
*/
`default_nettype none

module serial_host (
  // Serial link to the port
  output logic serial_clock,
  output logic port_select_enable,
  output logic serial_data_in,
  // Resolved shared pin level
  input wire logic pin_level
);
  timeunit 1ns;
  timeprecision 100ps;

  // Link idle: clock still, enable low after one clearing fall
  initial begin
    serial_clock = 1'b0;
    port_select_enable = 1'b1;
    serial_data_in = 1'b0;
    #1;
    port_select_enable = 1'b0;
  end

  // One frame; fewer than 32 edges aborts it
  task automatic frame(input logic rd, input logic [5:0] addr,
                       input logic [23:0] data, input int edges,
                       output logic [23:0] rdata);
    logic [30:0] word;
    word = {rd, addr, data};
    rdata = 'x;
    port_select_enable = 1'b1;
    serial_data_in = word[30];
    #32;
    for (int k = 1; k <= edges; k++) begin
      serial_clock = 1'b1;
      #32;
      serial_clock = 1'b0;
      // Address then data, MSB first, changed on falls
      if (k < 31) serial_data_in = word[30-k];
      if (k >= 8 && k <= 31) rdata[31-k] = pin_level;
      #32;
    end
    // Released only after fall 32 on a full frame
    port_select_enable = 1'b0;
    serial_data_in = ~serial_data_in;
    #32;
  endtask
endmodule

`default_nettype wire

// ---- test/tb_top.sv ----
/*
  Self-checking bench for the serial port slave with a host model.
  Assumes the host model and the design files compile before it.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [23:0] ID = 24'h3c5a96; // Arbitrary value
  logic clock, sys_rst, lock_detect, pin_o, pin_oe;
  logic [23:0] rd;
  wire logic serial_clock, port_select_enable, serial_data_in, pin_level;
  int err_count, n_checks;

  // Pin released when the driver is off
  assign pin_level = pin_oe ? pin_o : 1'bz;

  synth_serial_port_slave #(.DEVICE_ID(ID)) synth_serial_port_slave_i (
    .clock(clock), .sys_rst(sys_rst), .serial_clock(serial_clock),
    .port_select_enable(port_select_enable),
    .serial_data_in(serial_data_in), .lock_detect(lock_detect),
    .lock_or_readout_pin_o(pin_o), .lock_or_readout_pin_oe(pin_oe));

  serial_host serial_host_i (
    .serial_clock(serial_clock), .port_select_enable(port_select_enable),
    .serial_data_in(serial_data_in), .pin_level(pin_level));

  task automatic check(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] unused;
    serial_host_i.frame(1'b0, a, d, 32, unused);
    repeat (6) @(negedge clock);
  endtask

  task automatic rdreg(input logic [5:0] a, output logic [23:0] d);
    serial_host_i.frame(1'b1, a, 24'h000000, 32, d);
    repeat (6) @(negedge clock);
  endtask

  // Set lock status, let it settle, look at the idle pin
  task automatic idle(input logic ld, input logic exp_oe, input logic exp_o);
    @(negedge clock);
    lock_detect = ld;
    repeat (4) @(negedge clock);
    check("pin_oe", {23'h0, exp_oe}, {23'h0, pin_oe});
    if (exp_oe) check("pin_o", {23'h0, exp_o}, {23'h0, pin_o});
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // System clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Watchdog, several times the expected run
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end

  // Test sequence
  initial begin
    err_count = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    lock_detect = 1'b0;
    repeat (6) @(negedge clock);
    check("rst_oe", 24'h0, {23'h0, pin_oe});
    check("rst_o", 24'h0, {23'h0, pin_o});
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    idle(1'b1, 1'b1, 1'b1);
    idle(1'b0, 1'b1, 1'b0);
    $display("test defaults done");
    rdreg(6'h00, rd);
    check("identity", ID, rd);
    wr(6'h00, ~ID);
    rdreg(6'h00, rd);
    check("identity_ro", ID, rd);
    $display("test identity done");
    wr(6'h05, 24'h123456);
    rdreg(6'h05, rd);
    check("store", 24'h123456, rd);
    serial_host_i.frame(1'b0, 6'h05, 24'hedcba9, 31, rd);
    repeat (6) @(negedge clock);
    rdreg(6'h05, rd);
    check("aborted", 24'h123456, rd);
    $display("test write done");
    wr(6'h1a, 24'h002000);
    idle(1'b1, 1'b1, 1'b1);
    rdreg(6'h05, rd);
    check("lock_only", 24'hffffff, rd);
    $display("test lock_only done");
    wr(6'h02, 24'h000000);
    wr(6'h1a, 24'h000000);
    idle(1'b1, 1'b0, 1'b0);
    rdreg(6'h05, rd);
    check("pure_read", 24'h123456, rd);
    idle(1'b0, 1'b0, 1'b0);
    $display("test pure_mode done");
    // Auto sharing with the driver left to the read
    wr(6'h1a, 24'h001000);
    idle(1'b1, 1'b0, 1'b0);
    rdreg(6'h05, rd);
    check("auto_read", 24'h123456, rd);
    idle(1'b1, 1'b0, 1'b0);
    $display("test auto_mode done");
    report_and_stop();
  end
endmodule

`default_nettype wire
